// ==== verilog/rspo_ctrl.v ====
// output control of a resettable low-frequency oscillator
// assumes synchronous pin inputs and a 40 MHz clk_sys; one clock domain
//
// Behaviour
// RL1 - output held low through the whole start-up interval
// RL2 - normal polarity, reset low at start end: output starts toggling
// RL3 - normal polarity, reset high at start end: first pulse skipped
// RL4 - normal polarity: pulses keep being skipped while reset stays high
// RL5 - inverted polarity: low while code unknown, then code latched, output high
// RL6 - inverted, reset high at start end: output falls one master period later
// RL7 - inverted, reset low at start end: latch held, output stays high
// RL8 - system may assert reset to end the active interval early
// RL9 - system may hold the active interval at most half the period
// RL10 - output fed back to reset gives one short pulse per period
// RL11 - master rate near zero freezes the output at its level
// RL12 - rate change settles in under one output cycle
// RL13 - configuration picks a suitable, preferably lowest, divide ratio
// RL14 - 4-bit code sets polarity and ratio 1 to 2^21 in powers of 8
// RL15 - active reset clears latch; normal gives low, inverted gives high
// RL16 - master and dividers keep phase while reset is active
// RL17 - master passes fixed divide-by-1024 then the selected ratio
// RL18 - start-up is a master period counter, length a parameter
`timescale 1ns/1ps
`default_nettype none
`include "rspo_regs.vh"

module rspo_ctrl #(
  parameter STARTUP_TICKS = `RSPO_STARTUP_TICKS,
  parameter FILTER_TICKS = `RSPO_FILTER_TICKS,
  parameter PHASE_W = `RSPO_PHASE_W
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // pins facing the system
  input wire rstIn,
  input wire [`RSPO_CODE_W-1:0] divider_select_code,
  output reg outPin,
  // register port
  input wire [`RSPO_ADDR_W-1:0] regAddr,
  input wire [`RSPO_DATA_W-1:0] regWdata,
  input wire regWe,
  input wire regRe,
  output reg [`RSPO_DATA_W-1:0] regRdata
);

  localparam SW = 10;
  localparam ST_START = 1'b0;
  localparam ST_RUN = 1'b1;

  // software-written master period, in system clocks
  reg [`RSPO_MPERIOD_W-1:0] master_period_q;

  // state
  reg state_q;
  reg [SW-1:0] startCnt_q;
  reg [`RSPO_CODE_W-1:0] code_q;
  reg [PHASE_W-1:0] phase_q;
  reg latch_q;

  wire masterTick;
  wire [`RSPO_CODE_W-1:0] codeOk;

  // derived configuration
  wire invert_select;
  wire [2:0] ratioIdx;
  wire [4:0] lowBits;
  reg [PHASE_W-1:0] lowMask;
  reg [PHASE_W-1:0] halfVal;
  wire [PHASE_W-1:0] phaseLow;
  wire riseEv;
  wire fallEv;
  wire resetActive;
  reg outNext;

  // master oscillator as a tick enable; period zero stops it
  rspo_master_tick #(
    .W(`RSPO_MPERIOD_W)
  ) u_tick (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .mPeriod(master_period_q),
    .tick(masterTick)
  );

  // settled code, filtered so a moving input cannot glitch the output
  rspo_code_filter #(
    .FILT(FILTER_TICKS)
  ) u_filt (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick(masterTick),
    .codeRaw(divider_select_code),
    .codeOk(codeOk)
  );

  // polarity is the top code bit; inverted half mirrors the ratio order
  assign invert_select = code_q[`RSPO_CODE_POL]; // RL14
  assign ratioIdx = invert_select ? ~code_q[2:0] : code_q[2:0]; // RL14

  // period is 2^(10 + 3*idx) master ticks: fixed 1024 then 8^idx
  assign lowBits = 5'd`RSPO_FIXED_DIV_LOG2 + {ratioIdx, 1'b0} + {2'b00, ratioIdx}; // RL17

  // masks follow the live code, so a ratio change acts within one cycle
  always @* begin
    lowMask = {PHASE_W{1'b1}} >> (PHASE_W[4:0] - lowBits); // RL12
    halfVal = {{(PHASE_W-1){1'b0}}, 1'b1} << (lowBits - 5'd1);
  end

  assign phaseLow = phase_q & lowMask;
  assign riseEv = (phaseLow == {PHASE_W{1'b0}});
  assign fallEv = (phaseLow == halfVal);

  // active level of the reset pin depends on polarity
  assign resetActive = invert_select ? ~rstIn : rstIn; // RL15

  // start-up counter and code capture at its end
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_START;
      startCnt_q <= {SW{1'b0}};
      code_q <= {`RSPO_CODE_W{1'b0}};
    end else begin
      case (state_q)
        ST_START: begin
          if (masterTick) begin
            if (startCnt_q >= STARTUP_TICKS[SW-1:0] - {{(SW-1){1'b0}}, 1'b1}) begin
              state_q <= ST_RUN; // RL18
              code_q <= codeOk; // RL5
            end else begin
              startCnt_q <= startCnt_q + {{(SW-1){1'b0}}, 1'b1}; // RL18
            end
          end
        end
        ST_RUN: begin
          code_q <= codeOk; // RL12
        end
        default: begin
          state_q <= ST_START;
        end
      endcase
    end
  end

  // phase counter: held at zero in start-up, then free-running
  // it ignores the reset pin so pulse placement never shifts
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_q <= {PHASE_W{1'b0}};
    end else if (state_q == ST_RUN && masterTick) begin
      phase_q <= phase_q + {{(PHASE_W-1){1'b0}}, 1'b1}; // RL16
    end
  end

  // output state latch: set and ended by master ticks, cleared at once by active reset
  // with reset inactive, no tick means no edge, so a stalled master freezes the level
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latch_q <= 1'b0;
    end else if (state_q != ST_RUN) begin
      latch_q <= 1'b0; // RL1
    end else if (resetActive) begin
      latch_q <= 1'b0; // RL15 RL3 RL4 RL7 RL8 RL10
    end else if (masterTick && riseEv) begin
      latch_q <= 1'b1; // RL2 RL6
    end else if (masterTick && fallEv) begin
      latch_q <= 1'b0; // RL11
    end
  end

  // a rise while reset is active is simply lost: the pulse is skipped,
  // and reset can cut the active level short at any time

  // output buffer with optional inversion; low until code known
  always @* begin
    if (state_q != ST_RUN) begin
      outNext = 1'b0; // RL1
    end else if (invert_select) begin
      outNext = ~latch_q; // RL5
    end else begin
      outNext = latch_q;
    end
  end

  // registered pin; one clock of lag is far below a master period
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      outPin <= 1'b0;
    end else begin
      outPin <= outNext; // RL1
    end
  end

  // register writes
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      master_period_q <= `RSPO_MPERIOD_RST;
    end else if (regWe && regAddr == `RSPO_OFS_MPERIOD) begin
      master_period_q <= regWdata[`RSPO_MPERIOD_W-1:0]; // RL11
    end
  end

  // register reads: data stands the cycle after the strobe only
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      regRdata <= {`RSPO_DATA_W{1'b0}};
    end else if (regRe) begin
      case (regAddr)
        `RSPO_OFS_MPERIOD: begin
          regRdata <= {{(`RSPO_DATA_W-`RSPO_MPERIOD_W){1'b0}}, master_period_q};
        end
        `RSPO_OFS_STATUS: begin
          regRdata <= {24'h000000, code_q, resetActive, latch_q, state_q, outPin};
        end
        `RSPO_OFS_PHASE: begin
          regRdata <= {{(`RSPO_DATA_W-PHASE_W){1'b0}}, phase_q};
        end
        default: begin
          regRdata <= {`RSPO_DATA_W{1'b0}}; // unmapped reads as zero
        end
      endcase
    end else begin
      regRdata <= {`RSPO_DATA_W{1'b0}};
    end
  end

endmodule // rspo_ctrl
`default_nettype wire

// ==== verilog/rspo_regs.vh ====
// constants for the resettable slow pulse output block
// included by every design file of the block; definitions only
`ifndef RSPO_REGS_VH
`define RSPO_REGS_VH

// register offsets (byte addresses, one word each)
`define RSPO_ADDR_W 4
`define RSPO_OFS_MPERIOD 4'h0
`define RSPO_OFS_STATUS 4'h4
`define RSPO_OFS_PHASE 4'h8

// register widths and reset values
`define RSPO_DATA_W 32
`define RSPO_MPERIOD_W 16
`define RSPO_MPERIOD_RST 16'h0028

// status field positions
`define RSPO_ST_OUT 0
`define RSPO_ST_STARTED 1
`define RSPO_ST_LATCH 2
`define RSPO_ST_RSTACT 3
`define RSPO_ST_CODE_LO 4
`define RSPO_ST_CODE_HI 7

// timing counts in master periods, divider steps as log2, phase counter width
`define RSPO_STARTUP_TICKS 500
`define RSPO_FILTER_TICKS 4
`define RSPO_FIXED_DIV_LOG2 10
`define RSPO_RATIO_STEP_LOG2 3
`define RSPO_PHASE_W 31

// divider select code fields
`define RSPO_CODE_W 4
`define RSPO_CODE_POL 3

`endif

// ==== verilog/rspo_master_tick.v ====
// master oscillator model: one-cycle tick every mPeriod system clocks
// assumes mPeriod is steady software state; zero means stopped
`timescale 1ns/1ps
`default_nettype none
`include "rspo_regs.vh"

module rspo_master_tick #(
  parameter W = `RSPO_MPERIOD_W
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // period in system clocks
  input wire [W-1:0] mPeriod,
  // master tick out
  output reg tick
);

  reg [W-1:0] cnt_q;

  // a new period acts at once on the running count, so the period in progress may be cut short or stretched
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b0;
    end else if (mPeriod == {W{1'b0}}) begin
      tick <= 1'b0; // frozen: count cleared, no tick, no edge
      cnt_q <= {W{1'b0}};
    end else if (cnt_q >= mPeriod - {{(W-1){1'b0}}, 1'b1}) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

endmodule // rspo_master_tick
`default_nettype wire

// ==== verilog/rspo_code_filter.v ====
// digital filter on the divider select code
// a new code is accepted once it stands unchanged for FILT+1 master ticks after first being seen
`timescale 1ns/1ps
`default_nettype none
`include "rspo_regs.vh"

module rspo_code_filter #(
  parameter FILT = `RSPO_FILTER_TICKS
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // master tick and raw code
  input wire tick,
  input wire [`RSPO_CODE_W-1:0] codeRaw,
  // settled code
  output reg [`RSPO_CODE_W-1:0] codeOk
);

  reg [`RSPO_CODE_W-1:0] cand_q;
  reg [7:0] stable_q;

  // restart the count whenever the candidate moves
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cand_q <= {`RSPO_CODE_W{1'b0}};
      stable_q <= 8'h00;
      codeOk <= {`RSPO_CODE_W{1'b0}};
    end else if (tick) begin
      if (codeRaw != cand_q) begin
        cand_q <= codeRaw;
        stable_q <= 8'h00;
      end else if (stable_q >= FILT[7:0]) begin
        codeOk <= cand_q;
      end else begin
        stable_q <= stable_q + 8'h01;
      end
    end
  end

endmodule // rspo_code_filter
`default_nettype wire

// ==== bench/rspo_chk.sv ====
// checker for rspo_ctrl pins and register port
// bound to the top module; sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "rspo_regs.vh"
module rspo_chk #(parameter int STARTUP_TICKS = 4) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // pins
  input wire logic rstIn,
  input wire logic [3:0] divider_select_code,
  input wire logic outPin,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWe,
  input wire logic regRe,
  input wire logic [31:0] regRdata
);
  // first tick may come early, so one master period of slack
  localparam int LIM = (STARTUP_TICKS - 1) * 40;
  logic [15:0] upCnt_q;
  logic wrSeen_q;
  logic [15:0] mp_q;
  wire logic rstAct = divider_select_code[3] ? !rstIn : rstIn;
  // time since release and a shadow of the master period
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      upCnt_q <= 16'h0000;
      wrSeen_q <= 1'h0;
      mp_q <= `RSPO_MPERIOD_RST;
    end else begin
      if (upCnt_q != 16'hFFFF) upCnt_q <= upCnt_q + 16'h0001;
      if (regWe && regAddr == `RSPO_OFS_MPERIOD) begin
        wrSeen_q <= 1'h1;
        mp_q <= regWdata[15:0];
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // start-up bound holds only while the default period stands
  AST_STARTUP_LOW: assert property (!wrSeen_q && upCnt_q < LIM |-> !outPin)
    else $error("output high in start-up");
  AST_POL0_HOLD: assert property ((!divider_select_code[3] && rstIn) [*4] |-> !outPin)
    else $error("pulse not skipped");
  AST_POL1_HOLD: assert property (divider_select_code[3] && !rstIn && outPin |=> outPin)
    else $error("inverted hold lost");
  AST_RST_CLEAR: assert property ($rose(rstAct) && !divider_select_code[3]
    |-> ##[1:3] !outPin)
    else $error("reset did not cut pulse");
  // a tick already in flight when the write lands may still move the pin once
  AST_FREEZE: assert property ((mp_q == 16'h0000 && !rstAct) [*4] |-> $stable(outPin))
    else $error("output moved while frozen");
  AST_RD_IDLE: assert property (!$past(regRe) |-> regRdata == 32'h0)
    else $error("read data outside its cycle");
  AST_UNMAPPED: assert property (regRe && regAddr == 4'hC |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  AST_MP_READ: assert property (regRe && regAddr == `RSPO_OFS_MPERIOD
    |=> regRdata == {16'h0000, mp_q})
    else $error("period readback wrong");
endmodule // rspo_chk
bind rspo_ctrl rspo_chk #(.STARTUP_TICKS(STARTUP_TICKS)) chk (.clk_sys(clk_sys),
  .resetn(resetn), .rstIn(rstIn), .divider_select_code(divider_select_code),
  .outPin(outPin), .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe),
  .regRe(regRe), .regRdata(regRdata));
`default_nettype wire

// ==== bench/rspo_sys_model.sv ====
// system logic on the far side: drives the reset pin
// assumes bench sets sysRst and fbEn just after clock edges
`timescale 1ns/1ps
`default_nettype none
module rspo_sys_model #(parameter int DLY = 4) (
  // clock
  input wire logic clk_sys,
  // bench control
  input wire logic fbEn,
  input wire logic sysRst,
  // pins
  input wire logic outPin,
  output wire logic rstIn
);
  logic [DLY-1:0] dly_q = '0;
  // delay line in place of the rc on the reset pin
  always @(posedge clk_sys) dly_q <= {dly_q[DLY-2:0], outPin};
  // system cuts its on-time early, never past half a period
  assign rstIn = fbEn ? dly_q[DLY-1] : sysRst;
endmodule // rspo_sys_model
`default_nettype wire

// ==== bench/tb_rspo_ctrl.sv ====
// self-checking bench for rspo_ctrl with the system model on reset
// assumes a 40 MHz clock; start-up and filter shortened by parameter
`timescale 1ns/1ps
`default_nettype none
`include "rspo_regs.vh"
module tb_rspo_ctrl;
  typedef struct {logic [3:0] code; logic rst; logic rise; logic after;} rspo_row_t;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic sysRst = 1'h0;
  logic fbEn = 1'h0;
  logic [3:0] code = 4'h0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWe = 1'h0;
  logic regRe = 1'h0;
  wire logic rstIn;
  wire logic outPin;
  wire logic [31:0] regRdata;
  logic [31:0] rd;
  int failures = 0;
  int n_checks = 0;
  int n;
  int t0;
  int cyc = 0;
  // code, reset level, rises, level later
  rspo_row_t rows [4] = '{'{4'h0, 1'h0, 1'h1, 1'h1}, '{4'h0, 1'h1, 1'h0, 1'h0},
    '{4'h8, 1'h1, 1'h1, 1'h0}, '{4'hF, 1'h0, 1'h1, 1'h1}};
  rspo_ctrl #(.STARTUP_TICKS(4), .FILTER_TICKS(1)) uut (.clk_sys(clk_sys),
    .resetn(resetn), .rstIn(rstIn), .divider_select_code(code), .outPin(outPin),
    .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe), .regRe(regRe),
    .regRdata(regRdata));
  rspo_sys_model #(.DLY(4)) sys (.clk_sys(clk_sys), .fbEn(fbEn), .sysRst(sysRst),
    .outPin(outPin), .rstIn(rstIn));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic cmpWord(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmpBit(input string nm, input logic e, input logic g);
    cmpWord(nm, {31'h0, e}, {31'h0, g});
  endtask
  // counts clocks until the output shows lvl, or lim
  task automatic waitOut(input logic lvl, input int lim, output int k);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (outPin !== lvl && k < lim);
  endtask
  task automatic regWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWe <= 1'h1;
    @(posedge clk_sys);
    regWe <= 1'h0;
  endtask
  task automatic regRd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRe <= 1'h1;
    @(posedge clk_sys);
    regRe <= 1'h0;
    @(negedge clk_sys);
    d = regRdata;
  endtask
  task automatic doReset(input logic [3:0] c, input logic r);
    @(posedge clk_sys);
    resetn <= 1'h0;
    code <= c;
    sysRst <= r;
    fbEn <= 1'h0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'h1;
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, well above the expected run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      print_verdict;
    end
  end
  initial begin
    foreach (rows[i]) begin
      doReset(rows[i].code, rows[i].rst);
      waitOut(1'h1, 400, n);
      cmpBit("rise", rows[i].rise, outPin);
      if (rows[i].rise) cmpBit("late", 1'h1, n > 110);
      repeat (60) @(negedge clk_sys);
      cmpBit("after", rows[i].after, outPin);
    end
    // every code taken at start end, reset pin inactive
    for (int c = 0; c < 16; c++) begin
      doReset(c[3:0], c[3]);
      repeat (250) @(posedge clk_sys);
      regRd(`RSPO_OFS_STATUS, rd);
      cmpWord("code", c, {28'h0, rd[7:4]});
      cmpBit("started", 1'h1, rd[1]);
    end
    // lowest ratio suits the short period wanted here
    doReset(4'h0, 1'h0);
    regRd(`RSPO_OFS_MPERIOD, rd);
    cmpWord("mperiod", {16'h0, `RSPO_MPERIOD_RST}, rd);
    @(negedge clk_sys);
    cmpWord("idle", 32'h0, regRdata);
    regWr(4'hC, 32'h5);
    regRd(4'hC, rd);
    cmpWord("unmapped", 32'h0, rd);
    regWr(`RSPO_OFS_MPERIOD, 32'h2);
    regRd(`RSPO_OFS_MPERIOD, rd);
    cmpWord("mperiod", 32'h2, rd);
    // second pulse: 512 ticks of two clocks
    waitOut(1'h1, 3000, n);
    waitOut(1'h0, 3000, n);
    waitOut(1'h1, 3000, n);
    waitOut(1'h0, 3000, n);
    cmpWord("half", 32'h400, n);
    // cut a pulse short; next rise keeps the old phase
    waitOut(1'h1, 3000, n);
    t0 = cyc;
    repeat (100) @(posedge clk_sys);
    sysRst <= 1'h1;
    repeat (3) @(negedge clk_sys);
    cmpBit("cut", 1'h0, outPin);
    @(posedge clk_sys);
    sysRst <= 1'h0;
    waitOut(1'h1, 3000, n);
    cmpWord("phase", 32'h800, cyc - t0);
    // output fed back to reset through the delay
    // the pin is still high from the last pulse: let it drop, then time a whole one
    @(posedge clk_sys);
    fbEn <= 1'h1;
    waitOut(1'h0, 3000, n);
    waitOut(1'h1, 3000, n);
    waitOut(1'h0, 20, n);
    cmpBit("fbpulse", 1'h1, n >= 5 && n <= 8);
    // stopped master freezes the low level
    regWr(`RSPO_OFS_MPERIOD, 32'h0);
    fbEn <= 1'h0;
    waitOut(1'h1, 4200, n);
    cmpBit("frozen", 1'h0, outPin);
    // doubled master period: new half period within one cycle
    regWr(`RSPO_OFS_MPERIOD, 32'h4);
    waitOut(1'h1, 9000, n);
    waitOut(1'h0, 9000, n);
    cmpWord("half4", 32'h800, n);
    print_verdict;
  end
endmodule // tb_rspo_ctrl
`default_nettype wire
